// ==== core/mdt_consts.vh ====
// Purpose: shared constants for the modem dial timing control block
// Assumes: 10 MHz ref_clk
// Notes:   setting numbers are the command-visible register indices
`ifndef MDT_CONSTS_VH
`define MDT_CONSTS_VH
`define MDT_CLK_HZ         10000000
`define MDT_MS_PER_SEC     1000
`define MDT_CYC_PER_MS     (`MDT_CLK_HZ / 1000)
`define MDT_SEC_PER_MIN    60
`define MDT_NUM_RING       5'd0
`define MDT_NUM_DIALWAIT   5'd6
`define MDT_NUM_COMMA      5'd8
`define MDT_NUM_TONE       5'd11
`define MDT_NUM_ESCAPE     5'd13
`define MDT_NUM_RESTORAL   5'd18
`define MDT_NUM_DIALBACK   5'd19
`define MDT_RST_RING       8'h01
`define MDT_RST_DIALWAIT   8'h02
`define MDT_RST_COMMA      8'h02
`define MDT_RST_TONE       8'h46
`define MDT_RST_ESCAPE     8'h25
`define MDT_RST_RESTORAL   8'h1E
`define MDT_RST_DIALBACK   8'h01
`define MDT_ESC_MASK       8'h7F
`define MDT_ESC_REPEAT     2'd3
`define MDT_XON            8'h11
`define MDT_XOFF           8'h13
`define MDT_FIFO_W         8
`define MDT_FIFO_D         16
`define MDT_FIFO_AW        4
`define MDT_FIFO_HI        5'd12
`define MDT_FIFO_LO        5'd4
`endif

// ==== core/mdt_fifo.v ====
// Purpose: channel data FIFO in flip-flops
// Assumes: single clock, synchronous reset
// Notes:   full and empty come from a count
`timescale 1ns/100ps
`default_nettype none
module mdt_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  input  wire             ref_clk,
  input  wire             sys_rst,
  input  wire             clkEn,
  input  wire             inValid,
  output wire             inReady,
  input  wire [WIDTH-1:0] inData,
  output wire             outValid,
  input  wire             outReady,
  output wire [WIDTH-1:0] outData,
  output wire [AW:0]      fillLevel
);
  reg [WIDTH-1:0] memQ [0:DEPTH-1];
  reg [AW-1:0]    wrPtrQ;
  reg [AW-1:0]    rdPtrQ;
  reg [AW:0]      cntQ;
  wire            doWr;
  wire            doRd;

  assign inReady   = (cntQ != DEPTH[AW:0]);
  assign outValid  = (cntQ != {(AW+1){1'b0}});
  assign outData   = memQ[rdPtrQ];
  assign fillLevel = cntQ;
  assign doWr      = clkEn && inValid && inReady;
  assign doRd      = clkEn && outValid && outReady;

  always @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      wrPtrQ <= {AW{1'b0}};
      rdPtrQ <= {AW{1'b0}};
      cntQ   <= {(AW+1){1'b0}};
    end
    else
    begin
      if (doWr)
      begin
        memQ[wrPtrQ] <= inData;
        wrPtrQ       <= wrPtrQ + 1'b1;
      end
      if (doRd)
        rdPtrQ <= rdPtrQ + 1'b1;
      if (doWr && !doRd)
        cntQ <= cntQ + 1'b1;
      else if (doRd && !doWr)
        cntQ <= cntQ - 1'b1;
    end
  end
endmodule // mdt_fifo
`default_nettype wire

// ==== core/mdt_tick_gen.v ====
// Purpose: millisecond, second and minute strobes
// Assumes: 10 MHz ref_clk
// Notes:   strobes are one cycle wide and nest
`timescale 1ns/100ps
`default_nettype none
`include "mdt_consts.vh"
module mdt_tick_gen (
  input  wire ref_clk,
  input  wire sys_rst,
  input  wire clkEn,
  output reg  msTick,
  output reg  secTick,
  output reg  minTick
);
  localparam integer CYC_MS_I  = `MDT_CYC_PER_MS;
  localparam integer MS_SEC_I  = `MDT_MS_PER_SEC;
  localparam integer SEC_MIN_I = `MDT_SEC_PER_MIN;
  // Counters sized to the fixed rates; the cut is deliberate
  localparam [13:0]  CYC_MS    = CYC_MS_I[13:0];
  localparam [9:0]   MS_SEC    = MS_SEC_I[9:0];
  localparam [5:0]   SEC_MIN   = SEC_MIN_I[5:0];
  reg [13:0] cycQ;
  reg [9:0]  msQ;
  reg [5:0]  secQ;

  always @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      cycQ    <= 14'h0000;
      msQ     <= 10'h000;
      secQ    <= 6'h00;
      msTick  <= 1'b0;
      secTick <= 1'b0;
      minTick <= 1'b0;
    end
    else if (clkEn)
    begin
      msTick  <= 1'b0;
      secTick <= 1'b0;
      minTick <= 1'b0;
      if (cycQ == CYC_MS - 14'h0001)
      begin
        cycQ   <= 14'h0000;
        msTick <= 1'b1;
        if (msQ == MS_SEC - 10'h001)
        begin
          msQ     <= 10'h000;
          secTick <= 1'b1;
          if (secQ == SEC_MIN - 6'h01)
          begin
            secQ    <= 6'h00;
            minTick <= 1'b1;
          end
          else
            secQ <= secQ + 6'h01;
        end
        else
          msQ <= msQ + 10'h001;
      end
      else
        cycQ <= cycQ + 14'h0001;
    end
  end
endmodule // mdt_tick_gen
`default_nettype wire

// ==== core/mdt_dial_ctrl.v ====
// Purpose: setting registers, dial timers, escape detect and flow control
// Assumes: 10 MHz ref_clk; command parser outside decodes query and assign
// Notes:   rules listed below
`timescale 1ns/100ps
`default_nettype none
`include "mdt_consts.vh"
module mdt_dial_ctrl (
  input  wire       ref_clk,
  input  wire       sys_rst,
  input  wire       clkEn,
  input  wire       linkAccessOn,
  input  wire       linkAccessOff,
  input  wire       settingQuery,
  input  wire       settingAssign,
  input  wire [4:0] settingNum,
  input  wire [7:0] settingWrData,
  output reg  [7:0] settingRdData,
  output reg        settingRdValid,
  output reg        settingErr,
  output reg        linkAccessQ,
  input  wire       ringPin,
  output reg        answerCall,
  input  wire       dialCmd,
  input  wire       pauseChar,
  input  wire       busyDetect,
  input  wire       toneReq,
  output wire       dialBusy,
  output reg        dialStart,
  output reg        toneOn,
  output reg        retryCall,
  input  wire       remoteCharValid,
  input  wire [7:0] remoteChar,
  output reg        remoteConfigStart,
  input  wire       dialBackupMode,
  input  wire       leasedLineFail,
  output reg        restoralTest,
  output reg        dialBackActive,
  input  wire       hwFlowSel,
  input  wire       chanInValid,
  output wire       chanInReady,
  input  wire [7:0] chanInData,
  output wire       chanOutValid,
  input  wire       chanOutReady,
  output wire [7:0] chanOutData,
  input  wire       chanCtsPaceN,
  output reg        chanCts,
  output reg        flowCharValid,
  output reg  [7:0] flowChar,
  input  wire       flowCharReady
);
  localparam [2:0] ST_IDLE  = 3'd0;
  localparam [2:0] ST_WAIT  = 3'd1;
  localparam [2:0] ST_PAUSE = 3'd2;
  localparam [2:0] ST_TONE  = 3'd3;
  localparam [2:0] ST_GAP   = 3'd4;
  localparam [2:0] ST_BUSY  = 3'd5;

  reg  [7:0] ringSetQ, dialWaitQ, commaQ, toneQ, escQ, restoralQ, dialBackQ;
  reg  [2:0] stateQ;
  reg  [7:0] timerQ;
  reg  [7:0] ringCntQ;
  reg  [1:0] escCntQ;
  reg  [7:0] restoralCntQ;
  reg  [7:0] dialBackCntQ;
  reg        flowHaltQ;
  reg        pendCharQ;
  reg  [7:0] pendValQ;
  reg        ringS1Q, ringS2Q, ringS3Q, paceS1Q, paceS2Q;
  wire       msTick, secTick, minTick;
  wire [4:0] fillLevel;
  wire       fifoOutValid;
  wire       paceHold;

  function known;
    input [4:0] num;
    begin
      known = (num == `MDT_NUM_RING) || (num == `MDT_NUM_DIALWAIT) || (num == `MDT_NUM_COMMA) ||
              (num == `MDT_NUM_TONE) || (num == `MDT_NUM_ESCAPE) || (num == `MDT_NUM_RESTORAL) ||
              (num == `MDT_NUM_DIALBACK);
    end
  endfunction

  // Counter reload with zero treated as one, so it expires on the first tick
  function [7:0] loadVal;
    input [7:0] v;
    begin
      loadVal = (v == 8'h00) ? 8'h01 : v;
    end
  endfunction

  mdt_tick_gen uTick (
    .ref_clk (ref_clk),
    .sys_rst (sys_rst),
    .clkEn   (clkEn),
    .msTick  (msTick),
    .secTick (secTick),
    .minTick (minTick)
  );

  mdt_fifo #(.WIDTH(`MDT_FIFO_W), .DEPTH(`MDT_FIFO_D), .AW(`MDT_FIFO_AW)) uFifo (
    .ref_clk   (ref_clk),
    .sys_rst   (sys_rst),
    .clkEn     (clkEn),
    .inValid   (chanInValid),
    .inReady   (chanInReady),
    .inData    (chanInData),
    .outValid  (fifoOutValid),
    .outReady  (chanOutReady && !paceHold),
    .outData   (chanOutData),
    .fillLevel (fillLevel)
  );

  // Channel pacing follows the pace pin only with hardware flow control; none with software flow control
  assign paceHold     = hwFlowSel ? !paceS2Q : 1'b0;
  assign chanOutValid = fifoOutValid && !paceHold;
  assign dialBusy     = (stateQ != ST_IDLE);

  always @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      ringSetQ <= `MDT_RST_RING; dialWaitQ <= `MDT_RST_DIALWAIT; commaQ <= `MDT_RST_COMMA;
      toneQ <= `MDT_RST_TONE; escQ <= `MDT_RST_ESCAPE; restoralQ <= `MDT_RST_RESTORAL;
      dialBackQ <= `MDT_RST_DIALBACK;
      settingRdData <= 8'h00; settingRdValid <= 1'b0; settingErr <= 1'b0; linkAccessQ <= 1'b0;
      ringS1Q <= 1'b0; ringS2Q <= 1'b0; ringS3Q <= 1'b0; paceS1Q <= 1'b1; paceS2Q <= 1'b1;
      ringCntQ <= 8'h00; answerCall <= 1'b0;
      stateQ <= ST_IDLE; timerQ <= 8'h00; dialStart <= 1'b0; toneOn <= 1'b0; retryCall <= 1'b0;
      escCntQ <= 2'd0; remoteConfigStart <= 1'b0;
      restoralCntQ <= 8'h00; restoralTest <= 1'b0; dialBackCntQ <= 8'h00; dialBackActive <= 1'b0;
      flowHaltQ <= 1'b0; pendCharQ <= 1'b0; pendValQ <= 8'h00;
      chanCts <= 1'b1; flowCharValid <= 1'b0; flowChar <= 8'h00;
    end
    else if (clkEn)
    begin
      // Pins are asynchronous; stage two is read, and stage three for the ring edge
      ringS1Q <= ringPin; ringS2Q <= ringS1Q; ringS3Q <= ringS2Q;
      paceS1Q <= chanCtsPaceN; paceS2Q <= paceS1Q;

      settingRdValid <= 1'b0;
      settingErr     <= 1'b0;
      if (linkAccessOff)
        linkAccessQ <= 1'b0;
      else if (linkAccessOn)
        linkAccessQ <= 1'b1;
      // Commands while access is off are refused, not queued
      if ((settingQuery || settingAssign) && (!linkAccessQ || !known(settingNum)))
        settingErr <= 1'b1;
      else if (settingQuery)
      begin
        settingRdValid <= 1'b1;
        case (settingNum)
          `MDT_NUM_RING:     settingRdData <= ringSetQ;
          `MDT_NUM_DIALWAIT: settingRdData <= dialWaitQ;
          `MDT_NUM_COMMA:    settingRdData <= commaQ;
          `MDT_NUM_TONE:     settingRdData <= toneQ;
          `MDT_NUM_ESCAPE:   settingRdData <= escQ;
          `MDT_NUM_RESTORAL: settingRdData <= restoralQ;
          default:           settingRdData <= dialBackQ;
        endcase
      end
      else if (settingAssign)
      begin
        case (settingNum)
          `MDT_NUM_RING:     ringSetQ  <= settingWrData;
          `MDT_NUM_DIALWAIT: dialWaitQ <= settingWrData;
          `MDT_NUM_COMMA:    commaQ    <= settingWrData;
          `MDT_NUM_TONE:     toneQ     <= settingWrData; // Below 50 ms is stored as given
          `MDT_NUM_ESCAPE:   escQ      <= settingWrData & `MDT_ESC_MASK;
          `MDT_NUM_RESTORAL: restoralQ <= settingWrData;
          default:           dialBackQ <= settingWrData;
        endcase
      end

      // Ring counting on rising edges of the synchronised ring line
      answerCall <= 1'b0;
      if (ringS2Q && !ringS3Q && ringSetQ != 8'h00)
      begin
        if (ringCntQ + 8'h01 >= ringSetQ)
        begin
          answerCall <= 1'b1;
          ringCntQ   <= 8'h00;
        end
        else
          ringCntQ <= ringCntQ + 8'h01;
      end

      dialStart <= 1'b0;
      retryCall <= 1'b0;
      case (stateQ)
        ST_IDLE:
        begin
          toneOn <= 1'b0;
          if (dialCmd)
          begin
            stateQ <= ST_WAIT;
            timerQ <= loadVal(dialWaitQ);
          end
          else if (busyDetect)
          begin
            stateQ <= ST_BUSY;
            timerQ <= loadVal(commaQ);
          end
          else if (pauseChar && commaQ != 8'h00)
          begin
            stateQ <= ST_PAUSE;
            timerQ <= commaQ;
          end
          else if (toneReq)
          begin
            stateQ <= ST_TONE;
            toneOn <= 1'b1;
            timerQ <= loadVal(toneQ);
          end
        end
        // Waits and gaps share one down-counter; the tick and the end pulse differ
        ST_WAIT, ST_PAUSE, ST_BUSY, ST_GAP:
          if ((stateQ == ST_GAP) ? msTick : secTick)
          begin
            if (timerQ == 8'h01)
            begin
              dialStart <= (stateQ == ST_WAIT);
              retryCall <= (stateQ == ST_BUSY);
              stateQ    <= ST_IDLE;
            end
            timerQ <= timerQ - 8'h01;
          end
        ST_TONE:
          if (msTick)
          begin
            if (timerQ == 8'h01)
            begin
              toneOn <= 1'b0;
              stateQ <= ST_GAP;
              timerQ <= loadVal(toneQ);
            end
            else
              timerQ <= timerQ - 8'h01;
          end
        default:
          stateQ <= ST_IDLE;
      endcase

      // Any other character breaks the run of escapes
      remoteConfigStart <= 1'b0;
      if (remoteCharValid)
      begin
        if (remoteChar == escQ)
        begin
          if (escCntQ == `MDT_ESC_REPEAT - 2'd1)
          begin
            remoteConfigStart <= 1'b1;
            escCntQ           <= 2'd0;
          end
          else
            escCntQ <= escCntQ + 2'd1;
        end
        else
          escCntQ <= 2'd0;
      end

      restoralTest <= 1'b0;
      if (!dialBackupMode)
        restoralCntQ <= 8'h00;
      else if (minTick)
      begin
        if (restoralCntQ + 8'h01 >= restoralQ)
        begin
          restoralTest <= 1'b1;
          restoralCntQ <= 8'h00;
        end
        else
          restoralCntQ <= restoralCntQ + 8'h01;
      end

      // Zero setting gives no reconnection window at all
      if (leasedLineFail && !dialBackActive)
      begin
        dialBackActive <= (dialBackQ != 8'h00);
        dialBackCntQ   <= dialBackQ;
      end
      else if (dialBackActive && minTick)
      begin
        if (dialBackCntQ == 8'h01)
          dialBackActive <= 1'b0;
        dialBackCntQ <= dialBackCntQ - 8'h01;
      end

      // Hysteresis keeps flow signalling from chattering
      if (fillLevel >= `MDT_FIFO_HI)
        flowHaltQ <= 1'b1;
      else if (fillLevel <= `MDT_FIFO_LO)
        flowHaltQ <= 1'b0;
      chanCts <= hwFlowSel ? !flowHaltQ : 1'b1;
      if (flowCharValid && flowCharReady)
        flowCharValid <= 1'b0;
      else if (!hwFlowSel && pendCharQ && !flowCharValid)
      begin
        flowCharValid <= 1'b1;
        flowChar      <= pendValQ;
      end
      if (!hwFlowSel && (fillLevel >= `MDT_FIFO_HI) && !flowHaltQ)
      begin
        pendCharQ <= 1'b1;
        pendValQ  <= `MDT_XOFF;
      end
      else if (!hwFlowSel && (fillLevel <= `MDT_FIFO_LO) && flowHaltQ)
      begin
        pendCharQ <= 1'b1;
        pendValQ  <= `MDT_XON;
      end
      else if (!flowCharValid && pendCharQ)
        pendCharQ <= 1'b0;
    end
  end
endmodule // mdt_dial_ctrl
`default_nettype wire

// ==== verification/mdt_dial_ctrl_sva.sv ====
// Purpose: port checker for mdt_dial_ctrl
// Assumes: one clock, synchronous reset
// Notes:   bound to every instance of the block
`timescale 1ns/100ps
`default_nettype none
`include "mdt_consts.vh"
module mdt_dial_ctrl_sva (
  input wire logic       ref_clk,
  input wire logic       sys_rst,
  input wire logic       linkAccessOn,
  input wire logic       linkAccessOff,
  input wire logic       linkAccessQ,
  input wire logic       settingQuery,
  input wire logic       settingAssign,
  input wire logic [4:0] settingNum,
  input wire logic       settingRdValid,
  input wire logic       settingErr,
  input wire logic       dialCmd,
  input wire logic       dialBusy,
  input wire logic       remoteCharValid,
  input wire logic       remoteConfigStart,
  input wire logic       hwFlowSel,
  input wire logic       chanInReady,
  input wire logic       chanCts,
  input wire logic       flowCharValid,
  input wire logic [7:0] flowChar,
  input wire logic       flowCharReady
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  logic req;
  logic known;
  assign req = settingQuery | settingAssign;
  assign known = settingNum inside {`MDT_NUM_RING, `MDT_NUM_DIALWAIT, `MDT_NUM_COMMA, `MDT_NUM_TONE,
                                    `MDT_NUM_ESCAPE, `MDT_NUM_RESTORAL, `MDT_NUM_DIALBACK};
  AST_QUERY_OK: assert property (settingQuery && linkAccessQ && known |=> settingRdValid && !settingErr)
    else $error("query not answered");
  AST_NO_ACCESS: assert property (req && !linkAccessQ |=> settingErr && !settingRdValid)
    else $error("request without access not refused");
  AST_BAD_NUM: assert property (req && !known |=> settingErr)
    else $error("unknown setting not refused");
  AST_LINK_OFF: assert property (linkAccessOff |=> !linkAccessQ)
    else $error("access still on");
  AST_LINK_ON: assert property (linkAccessOn && !linkAccessOff |=> linkAccessQ)
    else $error("access not on");
  // Match may be registered once or twice
  AST_ESC_CAUSE: assert property (remoteConfigStart |-> $past(remoteCharValid) || $past(remoteCharValid, 2))
    else $error("remote config without char");
  AST_CTS_FULL: assert property (hwFlowSel && !chanInReady |-> !chanCts)
    else $error("full but clear to send");
  AST_FLOW_CODE: assert property (flowCharValid |-> flowChar == `MDT_XON || flowChar == `MDT_XOFF)
    else $error("bad flow char");
  AST_FLOW_HOLD: assert property (flowCharValid && !flowCharReady |=> flowCharValid && $stable(flowChar))
    else $error("flow char dropped");
  AST_DIAL_TAKEN: assert property (dialCmd && !dialBusy |=> dialBusy)
    else $error("dial not taken");
  cover property (settingRdValid);
  cover property (remoteConfigStart);
  cover property (flowCharValid && flowCharReady);
endmodule // mdt_dial_ctrl_sva
bind mdt_dial_ctrl mdt_dial_ctrl_sva mdt_dial_ctrl_sva_i (.ref_clk, .sys_rst, .linkAccessOn, .linkAccessOff,
  .linkAccessQ, .settingQuery, .settingAssign, .settingNum, .settingRdValid, .settingErr, .dialCmd, .dialBusy,
  .remoteCharValid, .remoteConfigStart, .hwFlowSel, .chanInReady, .chanCts, .flowCharValid, .flowChar,
  .flowCharReady);
`default_nettype wire

// ==== verification/mdt_chan_model.sv ====
// Purpose: channel device at the far side of the data path
// Assumes: drives on the falling edge like the bench
// Notes:   handshake decided here lands on the next rising edge
`timescale 1ns/100ps
`default_nettype none
module mdt_chan_model (
  input wire logic       ref_clk,
  input wire logic       stall,
  input wire logic       pace,
  input wire logic       chanOutValid,
  input wire logic [7:0] chanOutData,
  output var logic       chanOutReady,
  output var logic       chanCtsPaceN,
  input wire logic       flowCharValid,
  input wire logic [7:0] flowChar,
  output var logic       flowCharReady
);
  logic [7:0] rxQ[$];
  logic [7:0] lastFlow = 8'h00;
  logic       r;
  initial
  begin
    chanOutReady  = 1'b0;
    chanCtsPaceN  = 1'b1;
    flowCharReady = 1'b0;
  end
  // Random ready so the device sees slow sinks
  always @(negedge ref_clk)
  begin
    r = !stall && ($urandom_range(3) != 0);
    if (chanOutValid === 1'b1 && r)
      rxQ.push_back(chanOutData);
    chanOutReady <= r;
    chanCtsPaceN <= !pace;
    r = ($urandom_range(1) == 1);
    if (flowCharValid === 1'b1 && r)
      lastFlow <= flowChar;
    flowCharReady <= r;
  end
endmodule // mdt_chan_model
`default_nettype wire

// ==== verification/tb.sv ====
// Purpose: self-checking bench for mdt_dial_ctrl
// Assumes: 10 MHz ref_clk, inputs driven on the falling edge
// Notes:   second and minute timers too long to run; tone kept short
`timescale 1ns/100ps
`default_nettype none
`include "mdt_consts.vh"
module tb;
  logic ref_clk = 0, sys_rst = 1, linkAccessOn = 0, linkAccessOff = 0, settingQuery = 0, settingAssign = 0;
  logic ringPin = 0, dialCmd = 0, toneReq = 0, remoteCharValid = 0, hwFlowSel = 1, chanInValid = 0;
  logic stall = 0, pace = 0, settingRdValid, settingErr, linkAccessQ, answerCall, dialBusy, dialStart;
  logic toneOn, remoteConfigStart, chanInReady, chanOutValid, chanOutReady, chanCts, chanCtsPaceN;
  logic flowCharValid, flowCharReady;
  logic clkEn = 1, pauseChar = 0, busyDetect = 0, dialBackupMode = 0, leasedLineFail = 0;
  logic retryCall, restoralTest, dialBackActive;
  logic [4:0] settingNum = 0;
  logic [7:0] settingWrData = 0, remoteChar = 0, chanInData = 0, settingRdData, chanOutData, flowChar;
  int fails = 0, n_checks = 0, cyc = 0, nAns = 0, nEsc = 0, nDial = 0;
  logic [7:0] expQ[$];
  logic [4:0] nums[7] = '{`MDT_NUM_RING, `MDT_NUM_DIALWAIT, `MDT_NUM_COMMA, `MDT_NUM_TONE,
                          `MDT_NUM_ESCAPE, `MDT_NUM_RESTORAL, `MDT_NUM_DIALBACK};
  logic [7:0] rstv[7] = '{8'h01, 8'h02, 8'h02, 8'h46, 8'h25, 8'h1E, 8'h01};
  logic [7:0] lo[7] = '{8'h00, 8'h02, 8'h00, 8'h01, 8'h00, 8'h0A, 8'h00};
  logic [7:0] hi[7] = '{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h7F, 8'hFF, 8'hFF};
  mdt_dial_ctrl mdt_dial_ctrl_i (.ref_clk, .sys_rst, .clkEn, .linkAccessOn, .linkAccessOff, .settingQuery,
    .settingAssign, .settingNum, .settingWrData, .settingRdData, .settingRdValid, .settingErr, .linkAccessQ,
    .ringPin, .answerCall, .dialCmd, .pauseChar, .busyDetect, .toneReq, .dialBusy, .dialStart,
    .toneOn, .retryCall, .remoteCharValid, .remoteChar, .remoteConfigStart, .dialBackupMode,
    .leasedLineFail, .restoralTest, .dialBackActive, .hwFlowSel, .chanInValid, .chanInReady,
    .chanInData, .chanOutValid, .chanOutReady, .chanOutData, .chanCtsPaceN, .chanCts, .flowCharValid,
    .flowChar, .flowCharReady);
  mdt_chan_model mdt_chan_model_i (.ref_clk, .stall, .pace, .chanOutValid, .chanOutData, .chanOutReady,
    .chanCtsPaceN, .flowCharValid, .flowChar, .flowCharReady);
  always #50 ref_clk = ~ref_clk;
  // Pulses last one cycle, so one look per falling edge
  always @(negedge ref_clk)
  begin
    nAns += (answerCall === 1'b1);
    nEsc += (remoteConfigStart === 1'b1);
    nDial += (dialStart === 1'b1);
  end
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 90000)
    begin
      fails++;
      end_sim;
    end
  end
  task end_sim;
    if (fails == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task req(input logic q, input logic [4:0] num, input logic [7:0] wd, output logic [7:0] rd, output logic err);
    @(negedge ref_clk);
    settingQuery = q;
    settingAssign = !q;
    settingNum = num;
    settingWrData = wd;
    @(negedge ref_clk);
    settingQuery = 0;
    settingAssign = 0;
    for (int i = 0; i < 3 && settingRdValid !== 1'b1 && settingErr !== 1'b1; i++) @(negedge ref_clk);
    rd = settingRdData;
    err = settingErr;
  endtask
  task ring;
    @(negedge ref_clk) ringPin = 1;
    repeat (4) @(negedge ref_clk);
    ringPin = 0;
    repeat (4) @(negedge ref_clk);
  endtask
  task esc(input logic [7:0] c);
    @(negedge ref_clk);
    remoteCharValid = 1;
    remoteChar = c;
    @(negedge ref_clk) remoteCharValid = 0;
  endtask
  // Pushes until the FIFO shows full or lim words are sent; valid is raised only while ready is high, so no word is refused
  task fill(input int lim, output int n);
    n = 0;
    repeat (lim)
    begin
      @(negedge ref_clk);
      chanInValid = (chanInReady === 1'b1);
      if (!chanInValid)
        break;
      chanInData = 8'($urandom);
      expQ.push_back(chanInData);
      n++;
    end
    if (chanInValid)
      @(negedge ref_clk) chanInValid = 0;
  endtask
  task drain_chk;
    for (int i = 0; i < 500 && mdt_chan_model_i.rxQ.size() < expQ.size(); i++) @(negedge ref_clk);
    chk(mdt_chan_model_i.rxQ.size(), expQ.size());
    foreach (expQ[i]) chk(mdt_chan_model_i.rxQ[i], expQ[i]);
    mdt_chan_model_i.rxQ.delete();
    expQ.delete();
  endtask
  initial
  begin
    logic [7:0] rd, v, e;
    logic err;
    int n;
    void'($urandom(32'hBBB9));
    repeat (10) @(negedge ref_clk);
    sys_rst = 0;
    req(1, nums[0], 0, rd, err);
    chk(err, 1);
    @(negedge ref_clk) linkAccessOn = 1;
    @(negedge ref_clk) linkAccessOn = 0;
    chk(linkAccessQ, 1);
    foreach (nums[k])
    begin
      req(1, nums[k], 0, rd, err);
      chk({err, rd}, {1'b0, rstv[k]});
    end
    req(1, 5'h01, 0, rd, err);
    chk(err, 1);
    clkEn = 0;
    req(0, nums[0], 8'h07, rd, err);
    clkEn = 1;
    req(1, nums[0], 0, rd, err);
    chk({err, rd}, {1'b0, rstv[0]});
    for (int j = 0; j < 3; j++) foreach (nums[k])
    begin
      v = j == 0 ? hi[k] : j == 1 ? lo[k] : lo[k] + 8'($urandom_range(hi[k] - lo[k]));
      req(0, nums[k], v, rd, err);
      req(1, nums[k], 0, rd, err);
      chk({err, rd}, {1'b0, v});
    end
    n = $urandom_range(4, 2);
    req(0, `MDT_NUM_RING, 8'(n), rd, err);
    repeat (n - 1) ring;
    chk(nAns, 0);
    ring;
    chk(nAns, 1);
    req(0, `MDT_NUM_RING, 8'h00, rd, err);
    repeat (3) ring;
    chk(nAns, 1);
    e = 8'($urandom_range(127));
    req(0, `MDT_NUM_ESCAPE, e, rd, err);
    esc(e);
    esc(e);
    esc(e ^ 8'h01);
    esc(e);
    esc(e);
    chk(nEsc, 0);
    esc(e);
    @(negedge ref_clk);
    chk(nEsc, 1);
    // Short tone keeps the run small; real setups stay far longer
    req(0, `MDT_NUM_TONE, 8'h02, rd, err);
    req(1, `MDT_NUM_TONE, 0, rd, err);
    chk({err, rd}, 9'h002);
    @(negedge ref_clk) toneReq = 1;
    @(negedge ref_clk) toneReq = 0;
    for (n = 0; n < 12000 && toneOn !== 1'b1; n++) @(negedge ref_clk);
    for (n = 0; n < 30000 && toneOn === 1'b1; n++) @(negedge ref_clk);
    chk(n >= 10000 && n <= 20001, 1);
    for (n = 0; n < 30000 && dialBusy === 1'b1 && toneOn !== 1'b1; n++) @(negedge ref_clk);
    chk(n >= 10000 && n <= 20001, 1);
    stall = 1;
    fill(20, n);
    chk(n, `MDT_FIFO_D);
    chk(chanCts, 0);
    stall = 0;
    drain_chk;
    repeat (4) @(negedge ref_clk);
    chk(chanCts, 1);
    hwFlowSel = 0;
    stall = 1;
    fill(20, n);
    for (int i = 0; i < 60 && mdt_chan_model_i.lastFlow !== `MDT_XOFF; i++) @(negedge ref_clk);
    chk(mdt_chan_model_i.lastFlow, `MDT_XOFF);
    chk(chanCts, 1);
    stall = 0;
    drain_chk;
    for (int i = 0; i < 60 && mdt_chan_model_i.lastFlow !== `MDT_XON; i++) @(negedge ref_clk);
    chk(mdt_chan_model_i.lastFlow, `MDT_XON);
    hwFlowSel = 1;
    pace = 1;
    repeat (4) @(negedge ref_clk);
    fill(3, n);
    repeat (20) @(negedge ref_clk);
    chk(mdt_chan_model_i.rxQ.size(), 0);
    pace = 0;
    drain_chk;
    req(0, `MDT_NUM_COMMA, 8'h00, rd, err);
    req(0, `MDT_NUM_DIALBACK, 8'h01, rd, err);
    dialBackupMode = 1;
    @(negedge ref_clk) pauseChar = 1;
    @(negedge ref_clk) pauseChar = 0;
    chk(dialBusy, 0);
    @(negedge ref_clk) busyDetect = 1;
    leasedLineFail = 1;
    @(negedge ref_clk) busyDetect = 0;
    leasedLineFail = 0;
    chk({dialBusy, dialBackActive}, 2'b11);
    repeat (200) @(negedge ref_clk);
    chk({dialBusy, retryCall, restoralTest}, 3'b100);
    sys_rst = 1;
    repeat (2) @(negedge ref_clk);
    sys_rst = 0;
    chk({linkAccessQ, dialBusy, dialBackActive, chanCts}, 4'b0001);
    @(negedge ref_clk) linkAccessOn = 1;
    @(negedge ref_clk) linkAccessOn = 0;
    @(negedge ref_clk) dialCmd = 1;
    @(negedge ref_clk) dialCmd = 0;
    chk(dialBusy, 1);
    repeat (200) @(negedge ref_clk);
    chk(nDial, 0);
    @(negedge ref_clk) linkAccessOff = 1;
    @(negedge ref_clk) linkAccessOff = 0;
    req(1, nums[0], 0, rd, err);
    chk(err, 1);
    end_sim;
  end
endmodule // tb
`default_nettype wire
